// [logic/sdrx_defines.svh]
// constants for the sdlc receive framer and frame status queue
`ifndef SDRX_DEFINES_SVH
`define SDRX_DEFINES_SVH

// ==========================================================
// line patterns
`define SDRX_FLAG_PATTERN 8'h7E
`define SDRX_ABORT_ONES 3'h7
`define SDRX_STUFF_ONES 3'h5
`define SDRX_CHAR_BITS 8
`define SDRX_CRC_POLY 16'h1021
`define SDRX_CRC_GOOD 16'h1D0F

// ==========================================================
// frame status queue geometry
`define SDRX_QUEUE_DEPTH 10
`define SDRX_COUNT_W 14
`define SDRX_ENTRY_W 19
`define SDRX_ENT_CRC 14
`define SDRX_ENT_OVR 15
`define SDRX_ENT_RES_LSB 16

// ==========================================================
// read register bit positions
`define SDRX_CNTH_OVF 7
`define SDRX_CNTH_AVAIL 6
`define SDRX_RST_EOF 7
`define SDRX_RST_CRC 6
`define SDRX_RST_OVR 5
`define SDRX_RST_PAR 4
`define SDRX_RST_RES_LSB 1
`define SDRX_RST_ALLSENT 0

`endif

// [logic/sdrx_pkg.sv]
// types shared by the sdlc receive framer
package sdrx_pkg;
   typedef enum logic {sdrx_st_hunt, sdrx_st_sync} sdrx_rx_state_t;
   typedef logic [13:0] sdrx_count_t;
   typedef logic [2:0] sdrx_residue_t;
endpackage

// [logic/sdrx_status_queue.sv]
// frame status queue: byte count and status per received frame
`include "sdrx_defines.svh"
module sdrx_status_queue
   import sdrx_pkg::*;
#(
   parameter int DEPTH = `SDRX_QUEUE_DEPTH,
   parameter int WIDTH = `SDRX_ENTRY_W
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // control
   input wire logic clear,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   // state
   output logic [WIDTH-1:0] head,
   output logic empty,
   output logic full,
   output logic overflow
);
   localparam int PW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || WIDTH < `SDRX_ENTRY_W)
      begin : g_bad
         $error("sdrx_status_queue: depth or width too small");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] level;

   wire do_push = push && !full;
   // underflow guard: a pop on an empty queue is ignored
   wire do_pop = pop && !empty;
   wire [PW-1:0] wr_next = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
   wire [PW-1:0] rd_next = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

   assign head = mem[rd_ptr];
   assign empty = (level == '0);
   assign full = (level == (PW+1)'(DEPTH));

   always_ff @(posedge clk)
   begin
      if (ce && do_push)
         mem[wr_ptr] <= push_data;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
         overflow <= 1'b0;
      end
      else if (ce)
      begin
         if (clear)
         begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
            overflow <= 1'b0;
         end
         else
         begin
            if (do_push)
               wr_ptr <= wr_next;
            if (do_pop)
               rd_ptr <= rd_next;
            if (do_push && !do_pop)
               level <= level + 1'b1;
            else if (do_pop && !do_push)
               level <= level - 1'b1;
            // a store while full is lost and marks overflow
            if (push && full)
               overflow <= 1'b1;
         end
      end
   end
endmodule

// [logic/sdrx_frame_status.sv]
// sdlc receive framer with abort, hunt, modem pins and frame status queue
// Notes on behaviour
// - seven ones in a row is an abort, shown in break/abort status
// - each change of break/abort status raises an external/status event
// - an abort forces the receiver into hunt
// - abort status ends on the next zero bit, alone or in a flag
// - hunt ends only on a full flag, so abort and hunt clear separately
// - abort mid frame ends the frame and drops the partial character
// - request pin drives inverse of terminal ready bit unless used for dma
// - with auto enable, carrier pin high disables receiver, low enables it
// - without auto enable, carrier pin only feeds the carrier status bit and its external/status event
// - in hunt the receiver only compares the stream to the flag and watches for an abort
// - a flag in hunt gives sync; the next byte is the address
// - sync/hunt status shows hunt; each change raises an event
// - a received flag drives sync pin low for one receive clock
// - ten by nineteen status queue, enabled separately, apart from data
// - each entry holds a fourteen bit byte count and five status bits
// - byte count registers read only while the queue is enabled
// - closing flag stores count and status and presets the crc checker
// - a store into a full ten entry queue is a queue overrun
// - an aborted frame still stores its count; counter then restarts
// - overflow bit stays until the queue enable goes off and on
// - only a receive status read pops, never from an empty queue
// - stored status is residue, overrun and crc error only
`include "sdrx_defines.svh"
module sdrx_frame_status
   import sdrx_pkg::*;
#(
   parameter int QUEUE_DEPTH = `SDRX_QUEUE_DEPTH
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // serial line pins
   input wire logic rx_clk_pin,
   input wire logic rx_data_pin,
   input wire logic carrier_detect_pin_n,
   output logic sync_pin_n,
   output logic dtr_req_pin_n,
   // control bits
   input wire logic rx_enable,
   input wire logic auto_enable,
   input wire logic crc_preset_ones,
   input wire logic terminal_ready,
   input wire logic dtr_is_dma_req,
   input wire logic dma_req_n,
   input wire logic status_queue_enable,
   input wire logic special_cond_mode,
   input wire logic error_reset,
   input wire logic all_sent,
   input wire logic data_overrun,
   // main status bits
   output logic break_abort,
   output logic sync_hunt,
   output logic carrier_detect_bit,
   output logic ext_status_event,
   // received bytes toward the data fifo
   output logic [7:0] rx_byte,
   output logic rx_byte_valid,
   output logic rx_byte_is_address,
   output logic frame_end,
   output logic data_fifo_locked,
   // status reads
   input wire logic rd_count_high_status,
   input wire logic rd_count_low,
   input wire logic rd_receive_status,
   output logic [7:0] byte_count_high_status_register,
   output logic [7:0] byte_count_low_register,
   output logic [7:0] receive_status_register
);
   // ==========================================================
   // pin synchronisers and receive clock edge
   logic clk_s1, clk_s2, clk_d;
   logic dat_s1, dat_s2;
   logic dcd_s1, dcd_s2;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         {clk_s1, clk_s2, clk_d} <= 3'h0;
         {dat_s1, dat_s2} <= 2'h3;
         {dcd_s1, dcd_s2} <= 2'h3;
      end
      else if (ce)
      begin
         {clk_s1, clk_s2, clk_d} <= {rx_clk_pin, clk_s1, clk_s2};
         {dat_s1, dat_s2} <= {rx_data_pin, dat_s1};
         {dcd_s1, dcd_s2} <= {carrier_detect_pin_n, dcd_s1};
      end
   end

   wire rx_edge = clk_s2 && !clk_d;
   wire bit_in = dat_s2;
   wire step = ce && rx_edge;

   // ==========================================================
   // bit level decode
   sdrx_rx_state_t state;
   logic [7:0] raw;
   logic [2:0] ones;
   logic [7:0] dly;
   logic [3:0] dly_cnt;
   logic [7:0] chr;
   logic [2:0] bits;
   logic [15:0] crc;
   logic in_frame;
   logic first_byte;
   sdrx_count_t byte_count;
   logic frame_ovr;

   wire rx_off = !rx_enable || (auto_enable && dcd_s2);
   wire [7:0] next_raw = {raw[6:0], bit_in};
   wire flag_hit = (next_raw == `SDRX_FLAG_PATTERN);
   wire abort_hit = bit_in && (ones == `SDRX_ABORT_ONES - 3'h1);
   wire [2:0] next_ones = !bit_in ? 3'h0 :
      (ones == `SDRX_ABORT_ONES) ? ones : ones + 3'h1;
   wire in_sync = (state == sdrx_st_sync);
   wire stuffed = !bit_in && (ones == `SDRX_STUFF_ONES);
   wire push_bit = in_sync && !stuffed && !abort_hit;
   wire asm_valid = push_bit && (dly_cnt == 4'h8);
   wire asm_bit = dly[7];
   wire [7:0] next_chr = {asm_bit, chr[7:1]};
   wire byte_done = asm_valid && (bits == 3'h7);
   wire crc_fb = crc[15] ^ asm_bit;
   wire [15:0] next_crc = {crc[14:0], 1'b0} ^ (crc_fb ? `SDRX_CRC_POLY : 16'h0000);
   wire [15:0] crc_preset = crc_preset_ones ? 16'hFFFF : 16'h0000;
   wire close_hit = in_sync && flag_hit && (in_frame || asm_valid);
   wire abort_end = in_sync && abort_hit && (in_frame || dly_cnt == 4'h8);
   wire sdrx_residue_t residue = byte_done ? 3'h0 : bits + {2'h0, asm_valid};
   wire crc_bad = (asm_valid ? next_crc : crc) != `SDRX_CRC_GOOD;
   wire sdrx_count_t final_count = byte_count + {13'h0, byte_done};
   wire store = step && !rx_off && (close_hit || abort_end);
   // residue, overrun, crc error kept per entry
   wire [`SDRX_ENTRY_W-1:0] entry =
      {residue, frame_ovr || data_overrun, close_hit && crc_bad, final_count};

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= sdrx_st_hunt;
         raw <= 8'h00;
         ones <= 3'h0;
         dly <= 8'h00;
         dly_cnt <= 4'h0;
         chr <= 8'h00;
         bits <= 3'h0;
         crc <= 16'h0000;
         in_frame <= 1'b0;
         first_byte <= 1'b0;
         byte_count <= '0;
      end
      else if (ce && rx_off)
      begin
         state <= sdrx_st_hunt;
         ones <= 3'h0;
         dly_cnt <= 4'h0;
         bits <= 3'h0;
         in_frame <= 1'b0;
         byte_count <= '0;
      end
      else if (step)
      begin
         raw <= next_raw;
         ones <= next_ones;
         if (abort_hit)
         begin
            state <= sdrx_st_hunt;
            dly_cnt <= 4'h0;
            bits <= 3'h0;
            in_frame <= 1'b0;
            byte_count <= '0;
         end
         else if (flag_hit)
         begin
            // flag gives sync, next byte is address
            // crc checker preset on every flag
            state <= sdrx_st_sync;
            dly_cnt <= 4'h0;
            bits <= 3'h0;
            crc <= crc_preset;
            in_frame <= 1'b0;
            first_byte <= 1'b1;
            // cleared once the entry is stored
            byte_count <= '0;
         end
         // hunt does nothing beyond flag and abort compare
         else if (push_bit)
         begin
            dly <= {dly[6:0], bit_in};
            if (dly_cnt != 4'h8)
               dly_cnt <= dly_cnt + 4'h1;
            if (asm_valid)
            begin
               chr <= next_chr;
               bits <= bits + 3'h1;
               crc <= next_crc;
               in_frame <= 1'b1;
            end
            if (byte_done)
            begin
               byte_count <= byte_count + 1'b1;
               first_byte <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // status bits, events and pins
   logic sync_low;
   wire next_abort = rx_off ? 1'b0 :
      !rx_edge ? break_abort : abort_hit ? 1'b1 : bit_in ? break_abort : 1'b0;
   wire next_hunt = rx_off ? 1'b1 :
      !rx_edge ? sync_hunt : abort_hit ? 1'b1 : flag_hit ? 1'b0 : sync_hunt;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         break_abort <= 1'b0;
         sync_hunt <= 1'b1;
         carrier_detect_bit <= 1'b0;
         ext_status_event <= 1'b0;
         sync_low <= 1'b0;
         sync_pin_n <= 1'b1;
         dtr_req_pin_n <= 1'b1;
      end
      else if (ce)
      begin
         // abort seen / cleared by a zero
         break_abort <= next_abort;
         // hunt only leaves on a flag
         sync_hunt <= next_hunt;
         carrier_detect_bit <= !dcd_s2;
         // abort change event / hunt change event
         ext_status_event <= (next_abort != break_abort) || (next_hunt != sync_hunt)
            || (carrier_detect_bit == dcd_s2);
         // low from the flag edge to the next receive edge
         if (rx_edge)
            sync_low <= !rx_off && flag_hit;
         sync_pin_n <= !(rx_edge ? (!rx_off && flag_hit) : sync_low);
         // request pin or inverted terminal ready
         dtr_req_pin_n <= dtr_is_dma_req ? dma_req_n : !terminal_ready;
      end
   end

   // ==========================================================
   // received bytes and live frame status
   sdrx_residue_t live_res;
   logic live_crc, live_eof;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_byte <= 8'h00;
         rx_byte_valid <= 1'b0;
         rx_byte_is_address <= 1'b0;
         frame_end <= 1'b0;
         frame_ovr <= 1'b0;
         data_fifo_locked <= 1'b0;
         live_res <= 3'h0;
         live_crc <= 1'b0;
         live_eof <= 1'b0;
      end
      else if (ce)
      begin
         // a byte completed by the closing flag's last bit is still frame data
         rx_byte_valid <= step && !rx_off && byte_done && !abort_hit;
         frame_end <= store && close_hit;
         if (step && byte_done)
         begin
            rx_byte <= next_chr;
            rx_byte_is_address <= first_byte;
            live_eof <= 1'b0;
         end
         if (store)
            frame_ovr <= 1'b0;
         else if (data_overrun)
            frame_ovr <= 1'b1;
         if (store && close_hit)
         begin
            live_res <= residue;
            live_crc <= crc_bad;
            live_eof <= 1'b1;
         end
         // locked at end of frame until error reset; the set wins
         if (store && close_hit && special_cond_mode)
            data_fifo_locked <= 1'b1;
         else if (error_reset)
            data_fifo_locked <= 1'b0;
      end
   end

   // ==========================================================
   // frame status queue and its read registers
   logic [`SDRX_ENTRY_W-1:0] q_head;
   logic q_empty, q_full, q_ovf;
   logic avail_latched;

   // pop only on receive status read after a count high/status read
   wire q_pop = status_queue_enable && rd_receive_status && avail_latched;

   // queue enabled by its own bit / disable clears it
   // closing flag stores / overrun when full
   sdrx_status_queue #(
      .DEPTH(QUEUE_DEPTH),
      .WIDTH(`SDRX_ENTRY_W)
   ) u_queue (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .clear(!status_queue_enable),
      .push(store && status_queue_enable),
      .push_data(entry),
      .pop(q_pop),
      .head(q_head),
      .empty(q_empty),
      .full(q_full),
      .overflow(q_ovf)
   );

   wire [7:0] live_status = {live_eof, live_crc, frame_ovr, 1'b0, live_res, all_sent};
   wire [7:0] queue_status = {1'b1, q_head[`SDRX_ENT_CRC], q_head[`SDRX_ENT_OVR], 1'b0,
      q_head[`SDRX_ENTRY_W-1:`SDRX_ENT_RES_LSB], all_sent};

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         avail_latched <= 1'b0;
         byte_count_high_status_register <= 8'h00;
         byte_count_low_register <= 8'h00;
         receive_status_register <= 8'h00;
      end
      else if (ce)
      begin
         // count registers read as zero while queue is off
         if (rd_count_high_status)
         begin
            avail_latched <= status_queue_enable && !q_empty;
            byte_count_high_status_register <= !status_queue_enable ? 8'h00 :
               {q_ovf, !q_empty, q_head[13:8]};
         end
         else if (rd_receive_status || !status_queue_enable)
            avail_latched <= 1'b0;
         if (rd_count_low)
            byte_count_low_register <= status_queue_enable ? q_head[7:0] : 8'h00;
         if (rd_receive_status)
            receive_status_register <= q_pop ? queue_status : live_status;
      end
   end

   // ==========================================================
   // checks
   chk_abort_sets:
   assert property (@(posedge clk) disable iff (!rstn)
      step && !rx_off && abort_hit |=> break_abort && sync_hunt)
      else $error("abort not reported");
   chk_abort_zero:
   assert property (@(posedge clk) disable iff (!rstn)
      step && !rx_off && !bit_in |=> !break_abort)
      else $error("abort not cleared by zero");
   chk_hunt_holds:
   assert property (@(posedge clk) disable iff (!rstn)
      ce && sync_hunt && !(step && flag_hit) |=> sync_hunt)
      else $error("hunt left without flag");
   chk_event_change:
   assert property (@(posedge clk) disable iff (!rstn)
      $changed(break_abort) || $changed(sync_hunt) |-> ext_status_event)
      else $error("status change without event");
   chk_sync_release:
   assert property (@(posedge clk) disable iff (!rstn)
      !sync_pin_n ##1 (ce && rx_edge && !flag_hit) |=> sync_pin_n)
      else $error("sync pin low past one receive clock");
   chk_dtr_pin:
   assert property (@(posedge clk) disable iff (!rstn)
      ce && !dtr_is_dma_req |=> dtr_req_pin_n == !$past(terminal_ready))
      else $error("request pin not inverse of terminal ready");
   chk_auto_gate:
   assert property (@(posedge clk) disable iff (!rstn)
      ce && auto_enable && dcd_s2 |=> sync_hunt && !rx_byte_valid)
      else $error("receiver active with carrier high");
   chk_ovf_sticky:
   assert property (@(posedge clk) disable iff (!rstn)
      q_ovf && status_queue_enable |=> q_ovf)
      else $error("overflow cleared while enabled");
   chk_store_full:
   assert property (@(posedge clk) disable iff (!rstn)
      ce && store && status_queue_enable && q_full |=> q_ovf)
      else $error("store into full queue not flagged");
   chk_count_regs:
   assert property (@(posedge clk) disable iff (!rstn)
      ce && rd_count_low && !status_queue_enable |=> byte_count_low_register == 8'h00)
      else $error("count readable with queue off");
endmodule

// [sim/sdrx_remote_station.sv]
// remote sdlc station model that drives the receive clock and data pins
module sdrx_remote_station
(
   // serial line
   output logic line_clk,
   output logic line_data
);
   timeunit 1ns;
   timeprecision 100ps;

   int ones;

   initial
   begin
      line_clk = 1'b0;
      line_data = 1'b1;
      ones = 0;
   end

   // =========================================================
   // bit level
   // the clock stands low between calls, so no bit is seen between calls
   task automatic send_bit(input logic b);
      line_data = b;
      #80 line_clk = 1'b1;
      #80 line_clk = 1'b0;
   endtask

   task automatic send_raw(input int n, input logic b);
      repeat (n) send_bit(b);
   endtask

   // =========================================================
   // characters
   task automatic send_flag();
      for (int i = 0; i < 8; i++)
         send_bit(i != 0 && i != 7);
      ones = 0;
   endtask

   // lsb first, a zero after five ones keeps data apart from flags
   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
      begin
         send_bit(b[i]);
         ones = b[i] ? ones + 1 : 0;
         if (ones == 5)
         begin
            send_bit(1'b0);
            ones = 0;
         end
      end
   endtask
endmodule

// [sim/sdrx_frame_status_test.sv]
// testbench for the sdlc receive framer and its frame status queue
module sdrx_frame_status_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rstn, ce, rx_clk_pin, rx_data_pin, carrier_detect_pin_n;
   logic rx_enable, auto_enable, crc_preset_ones, terminal_ready, dtr_is_dma_req, dma_req_n;
   logic status_queue_enable, special_cond_mode, error_reset, all_sent, data_overrun;
   logic rd_count_high_status, rd_count_low, rd_receive_status;
   logic sync_pin_n, dtr_req_pin_n, break_abort, sync_hunt, carrier_detect_bit;
   logic ext_status_event, rx_byte_valid, rx_byte_is_address, frame_end, data_fifo_locked;
   logic [7:0] rx_byte, byte_count_high_status_register, byte_count_low_register;
   logic [7:0] receive_status_register, addr_seen;
   int fails, num_checks, ev_cnt, low_run, last_low, cycles, nbytes, nends;

   sdrx_frame_status #(.QUEUE_DEPTH(10)) u_sdrx_frame_status
   (
      .clk, .rstn, .ce, .rx_clk_pin, .rx_data_pin, .carrier_detect_pin_n, .sync_pin_n,
      .dtr_req_pin_n, .rx_enable, .auto_enable, .crc_preset_ones, .terminal_ready,
      .dtr_is_dma_req, .dma_req_n, .status_queue_enable, .special_cond_mode, .error_reset,
      .all_sent, .data_overrun, .break_abort, .sync_hunt, .carrier_detect_bit,
      .ext_status_event, .rx_byte, .rx_byte_valid, .rx_byte_is_address, .frame_end,
      .data_fifo_locked, .rd_count_high_status, .rd_count_low, .rd_receive_status,
      .byte_count_high_status_register, .byte_count_low_register, .receive_status_register
   );

   sdrx_remote_station u_sdrx_remote_station (.line_clk(rx_clk_pin), .line_data(rx_data_pin));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // =========================================================
   // monitors and timeout
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (ext_status_event === 1'b1)
         ev_cnt <= ev_cnt + 1;
      if (rx_byte_valid === 1'b1 && rx_byte_is_address === 1'b1)
         addr_seen <= rx_byte;
      if (rx_byte_valid === 1'b1)
         nbytes <= nbytes + 1;
      if (frame_end === 1'b1)
         nends <= nends + 1;
      if (sync_pin_n === 1'b0)
         low_run <= low_run + 1;
      else if (low_run != 0)
      begin
         last_low <= low_run;
         low_run <= 0;
      end
      if (cycles == 20000)
      begin
         fails++;
         report_and_stop();
      end
   end

   // =========================================================
   // helpers
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd(input int which, output logic [7:0] v);
      @(posedge clk);
      rd_count_high_status <= (which == 0);
      rd_count_low <= (which == 1);
      rd_receive_status <= (which == 2);
      @(posedge clk);
      rd_count_high_status <= 1'b0;
      rd_count_low <= 1'b0;
      rd_receive_status <= 1'b0;
      tick(2);
      v = which == 0 ? byte_count_high_status_register : byte_count_low_register;
      if (which == 2)
         v = receive_status_register;
   endtask

   // count high, count low, then receive status, which pops the entry
   task automatic entry(input logic [13:0] cnt, output logic [7:0] s);
      logic [7:0] h, l;
      rd(0, h);
      rd(1, l);
      rd(2, s);
      check("byte count", {2'h0, cnt}, {2'h0, h[5:0], l});
      check("data available", 16'h1, {15'h0, h[6]});
   endtask

   // =========================================================
   // scenarios
   task automatic t_modem();
      check("reset state", 16'h7, {12'h0, break_abort, sync_hunt, sync_pin_n, dtr_req_pin_n});
      @(posedge clk);
      terminal_ready <= 1'b1;
      tick(3);
      check("ready pin", 16'h0, {15'h0, dtr_req_pin_n});
      @(posedge clk);
      dtr_is_dma_req <= 1'b1;
      tick(3);
      check("request pin idle", 16'h1, {15'h0, dtr_req_pin_n});
      @(posedge clk);
      dma_req_n <= 1'b0;
      tick(3);
      check("request pin active", 16'h0, {15'h0, dtr_req_pin_n});
      @(posedge clk);
      carrier_detect_pin_n <= 1'b1;
      tick(1);
      u_sdrx_remote_station.send_flag();
      tick(10);
      check("carrier bit off", 16'h0, {15'h0, carrier_detect_bit});
      check("sync without auto", 16'h0, {15'h0, sync_hunt});
      @(posedge clk);
      auto_enable <= 1'b1;
      tick(1);
      u_sdrx_remote_station.send_flag();
      tick(10);
      check("hunt carrier off", 16'h1, {15'h0, sync_hunt});
      @(posedge clk);
      carrier_detect_pin_n <= 1'b0;
      tick(5);
      u_sdrx_remote_station.send_flag();
      tick(10);
      check("sync carrier on", 16'h0, {15'h0, sync_hunt});
      check("carrier bit on", 16'h1, {15'h0, carrier_detect_bit});
      $display("test modem done");
   endtask

   task automatic t_frame();
      logic [7:0] s, h;
      @(posedge clk);
      status_queue_enable <= 1'b1;
      tick(2);
      // data right behind a flag ends the sync pulse after one receive clock
      u_sdrx_remote_station.send_flag();
      {nbytes, nends} = {2{32'h0}};
      for (int i = 0; i < 4; i++)
         u_sdrx_remote_station.send_byte(8'h03 << i);
      check("sync pulse length", 16'h10, last_low[15:0]);
      u_sdrx_remote_station.send_flag();
      tick(10);
      check("address byte", 16'h03, {8'h0, addr_seen});
      check("bytes delivered", 16'h4, nbytes[15:0]);
      check("last byte", 16'h18, {8'h0, rx_byte});
      check("frame end pulses", 16'h1, nends[15:0]);
      entry(14'h4, s);
      check("frame status", 16'h81, {8'h0, s & 8'hBF});
      rd(0, h);
      check("queue drained", 16'h0, {15'h0, h[6]});
      $display("test frame done");
   endtask

   task automatic t_abort();
      logic [7:0] s;
      u_sdrx_remote_station.send_byte(8'h01);
      u_sdrx_remote_station.send_byte(8'h02);
      u_sdrx_remote_station.send_raw(3, 1'b0);
      u_sdrx_remote_station.send_raw(7, 1'b1);
      tick(10);
      check("abort and hunt", 16'h3, {14'h0, break_abort, sync_hunt});
      ev_cnt = 0;
      u_sdrx_remote_station.send_raw(1, 1'b0);
      tick(10);
      check("abort ended", 16'h1, {14'h0, break_abort, sync_hunt});
      check("abort end event", 16'h1, ev_cnt[15:0]);
      u_sdrx_remote_station.send_flag();
      tick(10);
      check("hunt end event", 16'h2, ev_cnt[15:0]);
      @(posedge clk);
      all_sent <= 1'b0;
      crc_preset_ones <= 1'b0;
      entry(14'h2, s);
      check("abort status", 16'h82, {8'h0, s});
      $display("test abort done");
   endtask

   task automatic t_overflow();
      logic [7:0] h;
      for (int i = 0; i < 11; i++)
      begin
         u_sdrx_remote_station.send_byte(8'h05);
         u_sdrx_remote_station.send_byte(8'h06);
         u_sdrx_remote_station.send_flag();
         if (i == 9)
         begin
            tick(10);
            rd(0, h);
            check("full no overflow", 16'h0, {15'h0, h[7]});
         end
      end
      tick(10);
      rd(0, h);
      check("overflow", 16'h3, {14'h0, h[7:6]});
      @(posedge clk);
      status_queue_enable <= 1'b0;
      tick(3);
      rd(1, h);
      check("count disabled", 16'h0, {8'h0, h});
      @(posedge clk);
      status_queue_enable <= 1'b1;
      tick(3);
      rd(0, h);
      check("overflow cleared", 16'h0, {8'h0, h});
      $display("test overflow done");
   endtask

   task automatic t_lock();
      logic [7:0] s;
      @(posedge clk);
      special_cond_mode <= 1'b1;
      data_overrun <= 1'b1;
      @(posedge clk);
      data_overrun <= 1'b0;
      tick(1);
      u_sdrx_remote_station.send_byte(8'h07);
      u_sdrx_remote_station.send_byte(8'h08);
      u_sdrx_remote_station.send_flag();
      tick(10);
      check("fifo locked", 16'h1, {15'h0, data_fifo_locked});
      entry(14'h2, s);
      check("overrun status", 16'hA0, {8'h0, s & 8'hBF});
      @(posedge clk);
      ce <= 1'b0;
      error_reset <= 1'b1;
      @(posedge clk);
      ce <= 1'b1;
      error_reset <= 1'b0;
      tick(2);
      check("frozen while disabled", 16'h1, {15'h0, data_fifo_locked});
      @(posedge clk);
      error_reset <= 1'b1;
      @(posedge clk);
      error_reset <= 1'b0;
      tick(2);
      check("fifo unlocked", 16'h0, {15'h0, data_fifo_locked});
      $display("test lock done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      {rstn, rx_enable, auto_enable, terminal_ready, dtr_is_dma_req} = 5'h0;
      {status_queue_enable, special_cond_mode, error_reset, data_overrun} = 4'h0;
      {rd_count_high_status, rd_count_low, rd_receive_status, carrier_detect_pin_n} = 4'h0;
      {ce, crc_preset_ones, dma_req_n, all_sent} = 4'hF;
      {fails, num_checks, ev_cnt, low_run, last_low, cycles, nbytes, nends} = {8{32'h0}};
      addr_seen = 8'h0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      tick(2);
      // receiver enabled only after the configuration
      @(posedge clk);
      rx_enable <= 1'b1;
      tick(2);
      t_modem();
      t_frame();
      t_abort();
      t_overflow();
      t_lock();
      report_and_stop();
   end
endmodule
